// file: rtl/dma_core.sv
// Multi-channel transfer controller core with APB registers and memory master
`timescale 1ns/1ns
`default_nettype none

module dma_core
   import dma_pkg::*;
(
   input wire logic pclk, // System clock, 50 MHz
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic [7:0] paddr, // APB byte address
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction, high for write
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic [NCH-1:0] event_in, // Incoming trigger events
   input wire logic [NPERIPH-1:0] periph_req, // Peripheral request lines
   output logic [NCH-1:0] beat_event_out, // Pulse after each beat
   output logic [NCH-1:0] block_event_out, // Pulse at block end
   output logic [NCH-1:0] block_irq_out, // Interrupt pulse at block end
   output logic mem_req, // Memory request, held until mem_ack
   output logic mem_we, // Memory write when high
   output logic [31:0] mem_addr, // Memory byte address
   output logic [31:0] mem_wdata, // Memory write data
   output logic [1:0] mem_size, // Beat width code of the access
   input wire logic mem_ack, // Memory accepts request this edge
   input wire logic [31:0] mem_rdata // Read data valid with mem_ack
);

   // ==========================================================================
   // Helpers
   // Address advance per beat, optionally scaled
   function automatic logic [31:0] step_of(input logic [15:0] bc, input logic scaled);
      logic [31:0] unit;
      unit = 32'(bc[BC_WIDTH_LSB +: 2]) + 32'h0000_0001;
      step_of = scaled ? (unit << bc[BC_STEP_LSB +: 3]) : unit;
   endfunction

   // Bitwise checksum update over the low nbits of d, MSB first
   function automatic logic [31:0] crc_feed(input logic [31:0] c, input logic [31:0] d,
                                            input logic [5:0] nbits, input logic wide);
      logic [31:0] r;
      logic fb;
      r = c;
      fb = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         if (i < int'(nbits)) begin
            fb = d[i] ^ (wide ? r[31] : r[15]);
            r = wide ? {r[30:0], 1'b0} : {16'h0000, r[14:0], 1'b0};
            if (fb) begin
               r = r ^ (wide ? POLY32 : POLY16);
            end
         end
      end
      crc_feed = r;
   endfunction

   // ==========================================================================
   // State
   logic ctrl_en_ff, nxt_ctrl_en;
   logic [3:0] crc_ctrl_ff, nxt_crc_ctrl;
   logic [31:0] crc_sum_ff, nxt_crc_sum;
   logic [31:0] desc_base_ff, nxt_desc_base;
   logic [31:0] wb_base_ff, nxt_wb_base;
   logic [1:0] chsel_ff, nxt_chsel;
   logic [CA_W-1:0] chca_ff [NCH], nxt_chca [NCH];
   logic [NCH-1:0] pend_ff, nxt_pend, busy_ff, nxt_busy;
   logic [NCH-1:0] susp_ff, nxt_susp, done_ff, nxt_done;
   logic [NCH-1:0] loaded_ff, nxt_loaded, chain_ff, nxt_chain;
   logic [15:0] bctl_ff [NCH], nxt_bctl [NCH];
   logic [16:0] beat_count_ff [NCH], nxt_beat_count [NCH];
   logic [31:0] src_ff [NCH], nxt_src [NCH];
   logic [31:0] dst_ff [NCH], nxt_dst [NCH];
   logic [31:0] next_ff [NCH], nxt_next [NCH];
   eng_state_t eng_ff, nxt_eng;
   logic [1:0] act_ff, nxt_act;
   logic [1:0] widx_ff, nxt_widx;
   logic [3:0] burst_ff, nxt_burst;
   logic [31:0] data_ff, nxt_data;
   logic mem_req_ff, nxt_mem_req, mem_we_ff, nxt_mem_we;
   logic [31:0] mem_addr_ff, nxt_mem_addr, mem_wdata_ff, nxt_mem_wdata;
   logic [1:0] mem_size_ff, nxt_mem_size;
   logic [NCH-1:0] bevt_ff, nxt_bevt, kevt_ff, nxt_kevt, kirq_ff, nxt_kirq;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;

   // Combinational helpers
   logic wr_acc;
   logic rd_setup;
   logic mapped;
   logic [NCH-1:0] trig_hit, elig;
   logic [1:0] gnt;
   logic [15:0] abc;
   logic [31:0] nsrc, ndst;
   logic [16:0] cnt_ld;

   // ==========================================================================
   // Trigger selection and fixed-priority arbiter, channel 0 highest
   always_comb begin
      trig_hit = '0;
      elig = '0;
      gnt = '0;
      for (int i = 0; i < NCH; i++) begin
         case (chca_ff[i][CA_TRIG_LSB +: 2])
            TRIG_EVT: trig_hit[i] = event_in[i];
            TRIG_PER: trig_hit[i] = periph_req[chca_ff[i][CA_PER_LSB +: 3]];
            default: trig_hit[i] = 1'b0;
         endcase
         if (wr_acc && paddr == A_SWTRIG && pwdata[i]) begin
            trig_hit[i] = 1'b1;
         end
         elig[i] = pend_ff[i] & chca_ff[i][CA_EN] & ~susp_ff[i];
      end
      for (int i = NCH - 1; i >= 0; i--) begin
         if (elig[i]) begin
            gnt = 2'(i);
         end
      end
   end

   // APB phase decode and address map check
   assign wr_acc = psel & penable & pready_ff & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign mapped = (paddr <= A_CHSTAT) && (paddr[1:0] == 2'b00);

   // Active descriptor view and next addresses of the active channel
   assign abc = bctl_ff[act_ff];
   assign nsrc = src_ff[act_ff] + (abc[BC_SOURCE_INCREMENT_ENABLE] ? step_of(abc, abc[BC_STEP_TARGET_SELECT]) : '0);
   assign ndst = dst_ff[act_ff] + (abc[BC_DESTINATION_INCREMENT_ENABLE] ? step_of(abc, ~abc[BC_STEP_TARGET_SELECT]) : '0);
   assign cnt_ld = (mem_rdata[31:BEAT_COUNT_LSB] == 16'h0000) ? BEAT_COUNT_MAX
                                                         : {1'b0, mem_rdata[31:BEAT_COUNT_LSB]};

   // ==========================================================================
   // Register file, channel state and transfer engine next values
   always_comb begin
      nxt_ctrl_en = ctrl_en_ff;
      nxt_crc_ctrl = crc_ctrl_ff;
      nxt_crc_sum = crc_sum_ff;
      nxt_desc_base = desc_base_ff;
      nxt_wb_base = wb_base_ff;
      nxt_chsel = chsel_ff;
      nxt_chca = chca_ff;
      nxt_pend = pend_ff;
      nxt_busy = busy_ff;
      nxt_susp = susp_ff;
      nxt_done = done_ff;
      nxt_loaded = loaded_ff;
      nxt_chain = chain_ff;
      nxt_bctl = bctl_ff;
      nxt_beat_count = beat_count_ff;
      nxt_src = src_ff;
      nxt_dst = dst_ff;
      nxt_next = next_ff;
      nxt_eng = eng_ff;
      nxt_act = act_ff;
      nxt_widx = widx_ff;
      nxt_burst = burst_ff;
      nxt_data = data_ff;
      nxt_mem_req = mem_req_ff;
      nxt_mem_we = mem_we_ff;
      nxt_mem_addr = mem_addr_ff;
      nxt_mem_wdata = mem_wdata_ff;
      nxt_mem_size = mem_size_ff;
      nxt_bevt = '0;
      nxt_kevt = '0;
      nxt_kirq = '0;
      nxt_pready = psel & ~penable;
      nxt_pslverr = psel & ~penable & ~mapped;
      nxt_prdata = '0;

      // Register writes
      if (wr_acc) begin
         case (paddr)
            A_CTRL: nxt_ctrl_en = pwdata[0];
            A_CRC_CTRL: nxt_crc_ctrl = pwdata[3:0];
            A_CRC_DIN: nxt_crc_sum = crc_feed(crc_sum_ff, pwdata, 6'd32,
                                             crc_ctrl_ff[CRC_POLY32]);
            A_CRC_SUM: nxt_crc_sum = pwdata;
            A_DESC_BASE: if (!ctrl_en_ff) nxt_desc_base = pwdata;
            A_WB_BASE: if (!ctrl_en_ff) nxt_wb_base = pwdata;
            A_CHSEL: nxt_chsel = pwdata[1:0];
            A_CHANNEL_CONTROL_A: begin
               nxt_chca[chsel_ff] = pwdata[CA_W-1:0];
               if (pwdata[CA_EN] && !chca_ff[chsel_ff][CA_EN]) begin
                  nxt_chain[chsel_ff] = 1'b0;
                  nxt_loaded[chsel_ff] = 1'b0;
               end
            end
            A_CHSTAT: begin
               if (pwdata[ST_SUSP]) nxt_susp[chsel_ff] = 1'b0;
               if (pwdata[ST_DONE]) nxt_done[chsel_ff] = 1'b0;
            end
            default: ;
         endcase
      end

      // Read data captured in the setup cycle
      if (rd_setup) begin
         case (paddr)
            A_CTRL: nxt_prdata = {31'h0000_0000, ctrl_en_ff};
            A_CRC_CTRL: nxt_prdata = {28'h000_0000, crc_ctrl_ff};
            A_CRC_SUM: nxt_prdata = crc_sum_ff;
            A_PEND: nxt_prdata = {28'h000_0000, pend_ff};
            A_BUSY: nxt_prdata = {28'h000_0000, busy_ff};
            A_DESC_BASE: nxt_prdata = desc_base_ff;
            A_WB_BASE: nxt_prdata = wb_base_ff;
            A_CHSEL: nxt_prdata = {30'h0000_0000, chsel_ff};
            A_CHANNEL_CONTROL_A: nxt_prdata = {20'h0_0000, chca_ff[chsel_ff]};
            A_CHSTAT: nxt_prdata = {28'h000_0000, done_ff[chsel_ff], susp_ff[chsel_ff],
                                    busy_ff[chsel_ff], pend_ff[chsel_ff]};
            default: nxt_prdata = '0;
         endcase
      end

      // Transfer engine
      case (eng_ff)
         eng_idle: begin
            if (ctrl_en_ff && |elig) begin
               nxt_act = gnt;
               nxt_busy[gnt] = 1'b1;
               nxt_burst = chca_ff[gnt][CA_BURST_LSB +: 4];
               nxt_mem_req = 1'b1;
               if (!loaded_ff[gnt]) begin
                  nxt_eng = eng_fetch;
                  nxt_widx = DW_CTRL;
                  nxt_mem_we = 1'b0;
                  nxt_mem_size = SIZE_WORD;
                  nxt_mem_addr = chain_ff[gnt] ? next_ff[gnt]
                                               : desc_base_ff + DESC_STRIDE * 32'(gnt);
               end else begin
                  nxt_eng = eng_read;
                  nxt_mem_we = 1'b0;
                  nxt_mem_size = bctl_ff[gnt][BC_WIDTH_LSB +: 2];
                  nxt_mem_addr = src_ff[gnt];
               end
            end
         end
         eng_fetch: begin
            if (mem_ack) begin
               nxt_mem_addr = mem_addr_ff + WORD_STEP;
               nxt_widx = widx_ff + 2'h1;
               case (widx_ff)
                  DW_CTRL: begin
                     nxt_bctl[act_ff] = mem_rdata[15:0];
                     nxt_beat_count[act_ff] = cnt_ld;
                  end
                  DW_SRC: nxt_src[act_ff] = mem_rdata;
                  DW_DST: nxt_dst[act_ff] = mem_rdata;
                  default: begin
                     nxt_next[act_ff] = mem_rdata;
                     nxt_loaded[act_ff] = 1'b1;
                     nxt_eng = eng_read;
                     nxt_mem_size = abc[BC_WIDTH_LSB +: 2];
                     nxt_mem_addr = src_ff[act_ff];
                  end
               endcase
            end
         end
         eng_read: begin
            if (mem_ack) begin
               nxt_data = mem_rdata;
               nxt_eng = eng_write;
               nxt_mem_we = 1'b1;
               nxt_mem_addr = dst_ff[act_ff];
               nxt_mem_wdata = mem_rdata;
            end
         end
         eng_write: begin
            if (mem_ack) begin
               nxt_mem_we = 1'b0;
               nxt_src[act_ff] = nsrc;
               nxt_dst[act_ff] = ndst;
               nxt_beat_count[act_ff] = beat_count_ff[act_ff] - BEAT_COUNT_ONE;
               nxt_burst = burst_ff - 4'h1;
               nxt_bevt[act_ff] = abc[BC_BEATEVT];
               if (crc_ctrl_ff[CRC_FROM_CH] && crc_ctrl_ff[CRC_CH_LSB +: 2] == act_ff) begin
                  nxt_crc_sum = crc_feed(crc_sum_ff, data_ff,
                                         6'(8 << abc[BC_WIDTH_LSB +: 2]),
                                         crc_ctrl_ff[CRC_POLY32]);
               end
               if (beat_count_ff[act_ff] == BEAT_COUNT_ONE) begin
                  nxt_eng = eng_idle;
                  nxt_mem_req = 1'b0;
                  nxt_pend[act_ff] = 1'b0;
                  nxt_busy[act_ff] = 1'b0;
                  nxt_loaded[act_ff] = 1'b0;
                  nxt_done[act_ff] = 1'b1;
                  nxt_kevt[act_ff] = abc[BC_BLKEVT];
                  nxt_kirq[act_ff] = abc[BC_BLKIRQ];
                  if (next_ff[act_ff] != '0) begin
                     nxt_chain[act_ff] = 1'b1;
                  end else begin
                     nxt_chain[act_ff] = 1'b0;
                     if (chca_ff[act_ff][CA_SUSP_END]) begin
                        nxt_susp[act_ff] = 1'b1;
                     end else begin
                        nxt_chca[act_ff][CA_EN] = 1'b0;
                     end
                  end
               end else if (burst_ff == 4'h0) begin
                  nxt_eng = eng_idle;
                  nxt_mem_req = 1'b0;
               end else begin
                  nxt_eng = eng_read;
                  nxt_mem_addr = nsrc;
               end
            end
         end
         default: nxt_eng = eng_idle;
      endcase

      // New triggers last, but a pending channel ignores them, so a same-cycle clear wins
      for (int i = 0; i < NCH; i++) begin
         if (trig_hit[i] && chca_ff[i][CA_EN] && !susp_ff[i] && !pend_ff[i]) begin
            nxt_pend[i] = 1'b1;
         end
      end
   end

   // ==========================================================================
   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_en_ff <= 1'b0;
         crc_ctrl_ff <= '0;
         crc_sum_ff <= '0;
         desc_base_ff <= '0;
         wb_base_ff <= '0;
         chsel_ff <= '0;
         for (int i = 0; i < NCH; i++) begin
            chca_ff[i] <= '0;
            bctl_ff[i] <= '0;
            beat_count_ff[i] <= '0;
            src_ff[i] <= '0;
            dst_ff[i] <= '0;
            next_ff[i] <= '0;
         end
         pend_ff <= '0;
         busy_ff <= '0;
         susp_ff <= '0;
         done_ff <= '0;
         loaded_ff <= '0;
         chain_ff <= '0;
         eng_ff <= eng_idle;
         act_ff <= '0;
         widx_ff <= '0;
         burst_ff <= '0;
         data_ff <= '0;
         mem_req_ff <= 1'b0;
         mem_we_ff <= 1'b0;
         mem_addr_ff <= '0;
         mem_wdata_ff <= '0;
         mem_size_ff <= '0;
         bevt_ff <= '0;
         kevt_ff <= '0;
         kirq_ff <= '0;
         prdata_ff <= '0;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         ctrl_en_ff <= nxt_ctrl_en;
         crc_ctrl_ff <= nxt_crc_ctrl;
         crc_sum_ff <= nxt_crc_sum;
         desc_base_ff <= nxt_desc_base;
         wb_base_ff <= nxt_wb_base;
         chsel_ff <= nxt_chsel;
         chca_ff <= nxt_chca;
         bctl_ff <= nxt_bctl;
         beat_count_ff <= nxt_beat_count;
         src_ff <= nxt_src;
         dst_ff <= nxt_dst;
         next_ff <= nxt_next;
         pend_ff <= nxt_pend;
         busy_ff <= nxt_busy;
         susp_ff <= nxt_susp;
         done_ff <= nxt_done;
         loaded_ff <= nxt_loaded;
         chain_ff <= nxt_chain;
         eng_ff <= nxt_eng;
         act_ff <= nxt_act;
         widx_ff <= nxt_widx;
         burst_ff <= nxt_burst;
         data_ff <= nxt_data;
         mem_req_ff <= nxt_mem_req;
         mem_we_ff <= nxt_mem_we;
         mem_addr_ff <= nxt_mem_addr;
         mem_wdata_ff <= nxt_mem_wdata;
         mem_size_ff <= nxt_mem_size;
         bevt_ff <= nxt_bevt;
         kevt_ff <= nxt_kevt;
         kirq_ff <= nxt_kirq;
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   // Outputs straight from flops
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign beat_event_out = bevt_ff;
   assign block_event_out = kevt_ff;
   assign block_irq_out = kirq_ff;
   assign mem_req = mem_req_ff;
   assign mem_we = mem_we_ff;
   assign mem_addr = mem_addr_ff;
   assign mem_wdata = mem_wdata_ff;
   assign mem_size = mem_size_ff;

endmodule // dma_core

`default_nettype wire

// file: rtl/dma_pkg.sv
// Constants, register map and types shared by the transfer controller
package dma_pkg;

   // ==========================================================================
   // Sizes
   localparam int NCH = 4;
   localparam int NPERIPH = 8;

   // ==========================================================================
   // Register byte addresses
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_CRC_CTRL = 8'h04;
   localparam logic [7:0] A_CRC_DIN = 8'h08;
   localparam logic [7:0] A_CRC_SUM = 8'h0C;
   localparam logic [7:0] A_SWTRIG = 8'h10;
   localparam logic [7:0] A_PEND = 8'h14;
   localparam logic [7:0] A_BUSY = 8'h18;
   localparam logic [7:0] A_DESC_BASE = 8'h1C;
   localparam logic [7:0] A_WB_BASE = 8'h20;
   localparam logic [7:0] A_CHSEL = 8'h24;
   localparam logic [7:0] A_CHANNEL_CONTROL_A = 8'h28;
   localparam logic [7:0] A_CHSTAT = 8'h2C;

   // ==========================================================================
   // channel_control_a fields
   localparam int CA_EN = 0;
   localparam int CA_SUSP_END = 1;
   localparam int CA_TRIG_LSB = 2;
   localparam int CA_PER_LSB = 4;
   localparam int CA_BURST_LSB = 8;
   localparam int CA_W = 12;
   localparam logic [1:0] TRIG_SW = 2'h0;
   localparam logic [1:0] TRIG_EVT = 2'h1;
   localparam logic [1:0] TRIG_PER = 2'h2;

   // ==========================================================================
   // block_control_word fields (low half of descriptor word 0) and beat count (high half)
   localparam int BC_WIDTH_LSB = 0;
   localparam int BC_SOURCE_INCREMENT_ENABLE = 2;
   localparam int BC_DESTINATION_INCREMENT_ENABLE = 3;
   localparam int BC_STEP_TARGET_SELECT = 4;
   localparam int BC_STEP_LSB = 5;
   localparam int BC_BEATEVT = 8;
   localparam int BC_BLKEVT = 9;
   localparam int BC_BLKIRQ = 10;
   localparam int BEAT_COUNT_LSB = 16;
   localparam logic [16:0] BEAT_COUNT_MAX = 17'h10000;
   localparam logic [16:0] BEAT_COUNT_ONE = 17'h00001;

   // ==========================================================================
   // Descriptor layout, status and checksum fields
   localparam logic [1:0] DW_CTRL = 2'h0;
   localparam logic [1:0] DW_SRC = 2'h1;
   localparam logic [1:0] DW_DST = 2'h2;
   localparam logic [1:0] DW_NEXT = 2'h3;
   localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;
   localparam logic [31:0] WORD_STEP = 32'h0000_0004;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam int ST_PEND = 0;
   localparam int ST_BUSY = 1;
   localparam int ST_SUSP = 2;
   localparam int ST_DONE = 3;
   localparam int CRC_POLY32 = 0;
   localparam int CRC_FROM_CH = 1;
   localparam int CRC_CH_LSB = 2;
   localparam logic [31:0] POLY16 = 32'h0000_1021;
   localparam logic [31:0] POLY32 = 32'h04C1_1DB7;

   typedef enum logic [1:0] {eng_idle, eng_fetch, eng_read, eng_write} eng_state_t;

endpackage

// file: tb/dma_mem_model.sv
// Behavioural memory on the far side of the controller's master port
`timescale 1ns/1ns
`default_nettype none
module dma_mem_model (
   input wire logic pclk, // Clock
   input wire logic mem_req, // Request
   input wire logic mem_we, // Write when high
   input wire logic [31:0] mem_addr, // Byte address
   input wire logic [31:0] mem_wdata, // Write data
   output logic mem_ack, // Request taken
   output logic [31:0] mem_rdata // Read data, junk outside ack
);
   logic [31:0] ram [0:63]; // Descriptors stay resident here
   int seed = 50963;
   logic go;
   initial begin
      mem_ack = 1'b0;
      mem_rdata = 32'h0;
   end
   // Random ack delay, store on taken write, inverted data while idle
   always @(posedge pclk) begin
      go = mem_req && !mem_ack && ({$random(seed)} % 3 == 0);
      if (mem_req && mem_ack && mem_we) ram[mem_addr[7:2]] <= mem_wdata;
      mem_ack <= go;
      mem_rdata <= go ? ram[mem_addr[7:2]] : ~mem_rdata;
   end
endmodule // dma_mem_model
`default_nettype wire

// file: tb/dma_core_checker.sv
// Concurrent checks on the transfer controller ports
`timescale 1ns/1ns
`default_nettype none
module dma_core_checker
   import dma_pkg::*;
(
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset, active low
   input wire logic [7:0] paddr, // APB address
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic [31:0] prdata, // APB read data
   input wire logic pready, // APB ready
   input wire logic pslverr, // APB error
   input wire logic [NCH-1:0] beat_event_out, // Beat events
   input wire logic [NCH-1:0] block_event_out, // Block events
   input wire logic [NCH-1:0] block_irq_out, // Block interrupts
   input wire logic mem_req, // Memory request
   input wire logic mem_we, // Memory write
   input wire logic [31:0] mem_addr, // Memory address
   input wire logic mem_ack // Memory accept
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ========
   // Register bus, master port and event outputs
   chk_ready_setup: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   chk_ready_cause: assert property (pready |-> $past(psel && !penable))
      else $error("pready without setup");
   chk_err_decode: assert property (pready |-> pslverr == (paddr > 8'h2C || paddr[1:0] != 2'h0))
      else $error("pslverr decode wrong");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero when idle");
   chk_req_hold: assert property (
      mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
      else $error("memory request dropped or changed");
   chk_beat_cause: assert property (
      |beat_event_out |-> $past(mem_req && mem_ack && mem_we))
      else $error("beat event without write");
   chk_one_active: assert property ($onehot0(beat_event_out))
      else $error("beats from two channels");
   chk_block_one: assert property ($onehot0(block_event_out | block_irq_out))
      else $error("block end on two channels");
   chk_irq_pulse: assert property (|block_irq_out |=> block_irq_out == '0)
      else $error("block interrupt longer than one cycle");
   cov_write: cover property (mem_req && mem_ack && mem_we);
   cov_irq: cover property (|block_irq_out);
   cov_err: cover property (pready && pslverr);
endmodule // dma_core_checker
bind dma_core dma_core_checker u_chk (.pclk, .presetn, .paddr, .psel, .penable, .prdata,
   .pready, .pslverr, .beat_event_out, .block_event_out, .block_irq_out, .mem_req, .mem_we,
   .mem_addr, .mem_ack);
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the transfer controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import dma_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_req, mem_we, mem_ack;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata;
   logic [1:0] mem_size;
   logic [NCH-1:0] event_in, beat_event_out, block_event_out, block_irq_out;
   logic [NPERIPH-1:0] periph_req;
   logic [63:0] rq[$];
   logic [63:0] wq[$];
   int miscompares = 0;
   int total_checks = 0;
   int seed = 50963;
   int nbeat = 0;
   int nblk = 0;
   dma_core uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .event_in, .periph_req, .beat_event_out, .block_event_out, .block_irq_out,
      .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_size, .mem_ack, .mem_rdata);
   dma_mem_model mem (.pclk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
   // Clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic check(input logic [63:0] s, input logic [63:0] e);
      total_checks++;
      if (s !== e) begin
         miscompares++;
         $display("Error at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         miscompares++;
         stop_test;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      rq.push_back({31'h0, e});
      apb(1'b0, a, 32'h0);
   endtask
   task automatic wait_irq(input int c);
      int n = 0;
      while (block_irq_out[c] !== 1'b1 && n < 500) begin
         @(posedge pclk);
         n++;
      end
      if (block_irq_out[c] !== 1'b1) begin
         miscompares++;
         stop_test;
      end
      @(posedge pclk);
   endtask
   task automatic desc(input int a, input logic [31:0] w0, s, d, nx);
      mem.ram[a/4] = w0;
      mem.ram[a/4+1] = s;
      mem.ram[a/4+2] = d;
      mem.ram[a/4+3] = nx;
   endtask
   task automatic beats(input logic [31:0] s, ss, d, ds, input int n);
      for (int i = 0; i < n; i++) wq.push_back({d + i * ds, mem.ram[6'((s + i * ss) >> 2)]});
   endtask
   // Scoreboard: each read answer and memory write against the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite)
         check({31'h0, pslverr, prdata}, rq.size() ? rq.pop_front() : '1);
      if (mem_req && mem_ack && mem_we)
         check({mem_addr, mem_wdata}, wq.size() ? wq.pop_front() : '1);
      if (mem_req && mem_ack)
         check(mem_size, 2'h2);
      nbeat += $countones(beat_event_out);
      nblk += $countones(block_event_out);
   end
   // Main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      event_in = 4'h0;
      periph_req = 8'h00;
      for (int i = 0; i < 64; i++) mem.ram[i] = $random(seed);
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h30, 33'h1_0000_0000);
      rd(A_PEND, 33'h0);
      apb(1, A_DESC_BASE, 32'h80);
      apb(1, A_CTRL, 32'h1);
      apb(1, A_DESC_BASE, 32'h40);
      rd(A_DESC_BASE, 33'h80);
      apb(1, A_CRC_DIN, 32'h2);
      rd(A_CRC_SUM, 33'h2042);
      apb(1, A_CRC_SUM, 32'h0);
      apb(1, A_CRC_CTRL, 32'h1);
      apb(1, A_CRC_DIN, 32'h2);
      rd(A_CRC_SUM, 33'h0982_3B6E);
      $display("Registers test done");
      desc(8'h80, 32'h0003_073E, 32'h0, 32'h40, 32'h0);
      beats(32'h0, 32'h6, 32'h40, 32'h3, 3);
      apb(1, A_CHSEL, 32'h0);
      apb(1, A_CHANNEL_CONTROL_A, 32'h101);
      apb(1, A_SWTRIG, 32'h1);
      apb(1, A_SWTRIG, 32'h1);
      wait_irq(0);
      check(nbeat, 3);
      check(nblk, 1);
      rd(A_CHSTAT, 33'h8);
      rd(A_CHANNEL_CONTROL_A, 33'h100);
      $display("Software trigger test done");
      desc(8'h90, 32'h0001_0602, 32'h08, 32'h48, 32'hC0);
      desc(8'hC0, 32'h0002_0406, 32'h10, 32'h50, 32'h0);
      beats(32'h08, 32'h0, 32'h48, 32'h0, 1);
      beats(32'h10, 32'h3, 32'h50, 32'h0, 2);
      apb(1, A_CHSEL, 32'h1);
      apb(1, A_CHANNEL_CONTROL_A, 32'h007);
      for (int k = 0; k < 2; k++) begin
         event_in <= 4'h2;
         @(posedge pclk);
         event_in <= 4'h0;
         wait_irq(1);
      end
      rd(A_CHSTAT, 33'hC);
      $display("Event trigger chain test done");
      desc(8'hA0, 32'h0001_0402, 32'h14, 32'h60, 32'h0);
      beats(32'h14, 32'h3, 32'h60, 32'h0, 1);
      apb(1, A_CHSEL, 32'h2);
      apb(1, A_CHANNEL_CONTROL_A, 32'h039);
      periph_req <= 8'h08;
      @(posedge pclk);
      periph_req <= 8'h00;
      wait_irq(2);
      rd(A_PEND, 33'h0);
      rd(A_BUSY, 33'h0);
      check(wq.size(), 0);
      check(nbeat, 3);
      check(nblk, 2);
      $display("Peripheral trigger test done");
      stop_test;
   end
endmodule // testbench
`default_nettype wire
